// ==== cfm_pkg.sv ====
package cfm_pkg;
	localparam int NUM_FILTERS = 16;
	localparam int EID_LOW_W   = 16;
	localparam int SID_W       = 11;
	localparam int MSEL_W      = 2;

	// Register word indices; byte address = 4 * index
	localparam logic [7:0] IDX_SID_BASE   = 8'h00;
	localparam logic [7:0] IDX_EID_BASE   = 8'h10;
	localparam logic [7:0] IDX_MSEL_LOW   = 8'h20;
	localparam logic [7:0] IDX_MSEL_HIGH  = 8'h21;
	localparam logic [7:0] IDX_CTRL       = 8'h22;
	localparam logic [7:0] IDX_STATUS     = 8'h23;

	// Companion identifier register fields
	localparam int SID_LSB     = 5;
	localparam int IDTYPE_BIT  = 3;
	localparam int EIDHI_LSB   = 0;
	localparam logic [15:0] SIDREG_WMASK = 16'hFFEB;

	// Control register fields
	localparam int CTRL_CHECK_EN = 0;

	// Reset values
	localparam logic [15:0] EID_RESET  = 16'h0000;
	localparam logic [15:0] SID_RESET  = 16'h0000;
	localparam logic [15:0] MSEL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Mask source codes
	localparam logic [1:0] MSEL_MASK0    = 2'h0;
	localparam logic [1:0] MSEL_MASK1    = 2'h1;
	localparam logic [1:0] MSEL_MASK2    = 2'h2;
	localparam logic [1:0] MSEL_RESERVED = 2'h3;

	typedef struct packed {
		logic        valid;
		logic        extended;
		logic [10:0] standard_id;
		logic [17:0] extended_id;
	} cfm_rx_id_t;

	typedef struct packed {
		logic [NUM_FILTERS-1:0]        hit;
		logic [NUM_FILTERS*MSEL_W-1:0] mask_select;
	} cfm_filter_out_t;
endpackage

// ==== cfm_filter.sv ====
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
import cfm_pkg::*;
// Notes on behaviour
// - Sixteen filters, each with its own writable extended-id low compare register.
// - Extended-id compare field is bits 15:0, bit n compares received id bit n.
// - Compare bit one matches only when received id bit is one.
// - Compare bit zero matches only when received id bit is zero.
// - Low selection register holds 2-bit mask source for filters 0..7, filter 7 on top.
// - High selection register holds filters 8..15 in the same layout.
// - With type check enabled, id type bit picks extended or standard only.
// - Companion register holds 11-bit standard id and extended id bits 17:16.
module cfm_filter (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [9:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	output logic                          wb_err_o,
	input  wire cfm_pkg::cfm_rx_id_t      rx_id,
	input  wire logic [3*29-1:0]          mask_bits,
	output cfm_pkg::cfm_filter_out_t      filter_out,
	output logic      [15:0]              filter_mask_reserved
);
	import cfm_pkg::*;

	logic [15:0] ext_id_reg [NUM_FILTERS];
	logic [15:0] sid_reg    [NUM_FILTERS];
	logic [15:0] msel_low_reg;
	logic [15:0] msel_high_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] last_hit_reg;
	logic [15:0] hit_next;
	logic [31:0] msel_all;
	logic        ack_reg;
	logic        err_reg;
	logic [31:0] dat_reg;
	logic [7:0]  idx;
	logic        req;
	logic        wr_lo;
	logic        wr_hi;
	logic        mapped;

	assign idx    = wb_adr_i[9:2];
	assign req    = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
	assign wr_lo  = req && wb_we_i && wb_sel_i[0];
	assign wr_hi  = req && wb_we_i && wb_sel_i[1];
	assign mapped = (idx < IDX_MSEL_LOW) || (idx <= IDX_STATUS);
	assign msel_all = {msel_high_reg, msel_low_reg};

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
			input logic lo, input logic hi);
		merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
	endfunction

	// Filter compare value registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_FILTERS; i++) begin
				ext_id_reg[i] <= EID_RESET;
				sid_reg[i]    <= SID_RESET;
			end
		end else if (wr_lo || wr_hi) begin
			if (idx[7:4] == IDX_EID_BASE[7:4]) begin
				ext_id_reg[idx[3:0]] <= merge(ext_id_reg[idx[3:0]], wb_dat_i[15:0], wr_lo, wr_hi);
			end else if (idx[7:4] == IDX_SID_BASE[7:4]) begin
				sid_reg[idx[3:0]] <= merge(sid_reg[idx[3:0]], wb_dat_i[15:0] & SIDREG_WMASK,
					wr_lo, wr_hi);
			end
		end
	end

	// Selection and control registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			msel_low_reg  <= MSEL_RESET;
			msel_high_reg <= MSEL_RESET;
			ctrl_reg      <= CTRL_RESET;
		end else begin
			if (idx == IDX_MSEL_LOW) begin
				msel_low_reg <= merge(msel_low_reg, wb_dat_i[15:0], wr_lo, wr_hi);
			end
			if (idx == IDX_MSEL_HIGH) begin
				msel_high_reg <= merge(msel_high_reg, wb_dat_i[15:0], wr_lo, wr_hi);
			end
			if (idx == IDX_CTRL) begin
				ctrl_reg <= merge(ctrl_reg, wb_dat_i[15:0], wr_lo, wr_hi) & 16'h0001;
			end
		end
	end

	// Acceptance compare, one result per filter
	always_comb begin
		for (int f = 0; f < NUM_FILTERS; f++) begin
			logic [1:0]  sel;
			logic [28:0] msk;
			logic [28:0] want;
			logic [28:0] got;
			logic        type_ok;
			sel  = msel_all[f*MSEL_W +: MSEL_W];
			msk  = '0;
			case (sel)
				MSEL_MASK0: msk = mask_bits[0 +: 29];
				MSEL_MASK1: msk = mask_bits[29 +: 29];
				MSEL_MASK2: msk = mask_bits[58 +: 29];
				default:    msk = '0;
			endcase
			want = {sid_reg[f][15:SID_LSB], sid_reg[f][EIDHI_LSB +: 2], ext_id_reg[f]};
			got  = {rx_id.standard_id, rx_id.extended_id};
			type_ok = !ctrl_reg[CTRL_CHECK_EN] || (sid_reg[f][IDTYPE_BIT] == rx_id.extended);
			// Equal bits compare both ways: one needs one, zero needs zero
			hit_next[f] = rx_id.valid && type_ok && (sel != MSEL_RESERVED)
				&& (((want ^ got) & msk) == 29'h0);
		end
	end

	// Latched result so outputs come from flip-flops
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			last_hit_reg <= 16'h0000;
		end else if (rx_id.valid) begin
			last_hit_reg <= hit_next;
		end
	end

	assign filter_out.hit         = last_hit_reg;
	assign filter_out.mask_select = msel_all;

	always_comb begin
		for (int f = 0; f < NUM_FILTERS; f++) begin
			filter_mask_reserved[f] = (msel_all[f*MSEL_W +: MSEL_W] == MSEL_RESERVED);
		end
	end

	// Wishbone answer: one cycle after request, error for unmapped words
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req && mapped;
			err_reg <= req && !mapped;
			if (req && !wb_we_i) begin
				if (idx[7:4] == IDX_EID_BASE[7:4]) begin
					dat_reg <= {16'h0000, ext_id_reg[idx[3:0]]};
				end else if (idx[7:4] == IDX_SID_BASE[7:4]) begin
					dat_reg <= {16'h0000, sid_reg[idx[3:0]]};
				end else if (idx == IDX_MSEL_LOW) begin
					dat_reg <= {16'h0000, msel_low_reg};
				end else if (idx == IDX_MSEL_HIGH) begin
					dat_reg <= {16'h0000, msel_high_reg};
				end else if (idx == IDX_CTRL) begin
					dat_reg <= {16'h0000, ctrl_reg};
				end else if (idx == IDX_STATUS) begin
					dat_reg <= {16'h0000, last_hit_reg};
				end else begin
					dat_reg <= 32'h0000_0000;
				end
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = dat_reg;
endmodule // cfm_filter

// ==== cfm_filter_props.sv ====
`timescale 1ns/1ps
module cfm_filter_props (
	input wire logic	clk,
	input wire logic	reset,
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_we_i,
	input wire logic [9:0]	wb_adr_i,
	input wire logic	wb_ack_o,
	input wire logic	wb_err_o,
	input wire cfm_pkg::cfm_rx_id_t	rx_id,
	input wire cfm_pkg::cfm_filter_out_t	filter_out,
	input wire logic [15:0]	filter_mask_reserved
);
	import cfm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// A request held through its answer is not a new one
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	chk_ack_mapped: assert property (req_s ##0 wb_adr_i[9:2] < 8'h24 |=> wb_ack_o && !wb_err_o) else $error("no ack");
	chk_err_unmapped: assert property (req_s ##0 wb_adr_i[9:2] > 8'h23 |=> wb_err_o && !wb_ack_o) else $error("no err");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	chk_hit_held: assert property (!rx_id.valid |=> $stable(filter_out.hit)) else $error("hit moved");
	chk_sel_write: assert property (!$stable(filter_out.mask_select) |-> wb_ack_o && $past(wb_we_i)) else $error("sel moved");
	chk_res_low: assert property (filter_mask_reserved[0] == (filter_out.mask_select[1:0] == 2'h3)) else $error("res 0");
	chk_res_high: assert property (filter_mask_reserved[15] == (filter_out.mask_select[31:30] == 2'h3)) else $error("res 15");
	chk_res_nohit: assert property (rx_id.valid && filter_mask_reserved[8] |=> !filter_out.hit[8]) else $error("res hit");
endmodule // cfm_filter_props
bind cfm_filter cfm_filter_props cfm_filter_props_inst (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.rx_id(rx_id), .filter_out(filter_out), .filter_mask_reserved(filter_mask_reserved));

// ==== cfm_rx_model.sv ====
`timescale 1ns/1ps
module cfm_rx_model (
	input wire logic	clk,
	input wire cfm_pkg::cfm_rx_id_t	next_id,
	output cfm_pkg::cfm_rx_id_t	rx_id
);
	import cfm_pkg::*;
	// Between frames the id fields flip, so a stale id cannot pass as fresh
	always_ff @(posedge clk) rx_id <= next_id.valid ? next_id : {1'b0, ~rx_id[29:0]};
endmodule // cfm_rx_model

// ==== cfm_filter_tb_top.sv ====
`timescale 1ns/1ps
module cfm_filter_tb_top;
	import cfm_pkg::*;
	logic	clk = 0, reset = 1, cyc = 0, we = 0, vd = 0;
	logic [9:0]	adr = '0;
	logic [31:0]	dat = '0, msel = '0;
	logic [3:0]	sel = '0;
	logic [15:0]	ereg [16];
	logic [16:0]	q [$];
	logic [16:0]	got;
	cfm_rx_id_t	nid = '0, rid;
	cfm_filter_out_t	fo;
	int	fails = 0, checks = 0;
	// Type check state mirrored here so expectations come from the rules, not the design
	logic	chk = 0;
	logic [15:0]	xt = '0;
	wire [31:0]	dato;
	wire	ack, err;
	initial forever #4 clk = ~clk;
	cfm_rx_model cfm_rx_model_inst (.clk(clk), .next_id(nid), .rx_id(rid));
	cfm_filter cfm_filter_inst (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err),
		.rx_id(rid), .mask_bits({29'h1FFFFFFF, 29'h0, 29'h0FFFF}), .filter_out(fo), .filter_mask_reserved());
	task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
		if (!w) q.push_back({idx > 8'h23, idx > 8'h23 ? 16'h0 : d});
		@(posedge clk);
		cyc <= 1;
		we <= w;
		adr <= {idx, 2'h0};
		dat <= {16'h0, d};
		sel <= 4'h3;
		do @(posedge clk); while (!(ack | err));
		cyc <= 0;
	endtask
	// Mask 0 compares the low id bits, mask 1 nothing, mask 2 every bit
	task automatic send(input logic [10:0] s, input logic [17:0] e, input logic x);
		logic [15:0] h;
		for (int f = 0; f < 16; f++) begin
			case (msel[2*f +: 2])
				2'h0: h[f] = ereg[f] == e[15:0];
				2'h1: h[f] = 1'b1;
				2'h2: h[f] = ereg[f] == e[15:0] && s == 0 && e[17:16] == 0;
				default: h[f] = 1'b0;
			endcase
			h[f] = h[f] && (!chk || xt[f] == x);
		end
		q.push_back({1'b0, h});
		@(posedge clk);
		nid <= '{1'b1, x, s, e};
		@(posedge clk);
		nid.valid <= 0;
		repeat (3) @(posedge clk);
	endtask
	task automatic conclude;
		if (fails == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk) vd <= rid.valid;
	always @(negedge clk) if (((ack | err) && !we) || vd) begin
		got = vd ? {1'b0, fo.hit} : {err, err ? 16'h0 : dato[15:0]};
		checks++;
		if (q[0] !== got) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, q[0]);
		end
		void'(q.pop_front());
	end
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		conclude;
	end
	initial begin
		void'($urandom(98));
		repeat (5) @(posedge clk);
		reset <= 0;
		bus(0, IDX_EID_BASE, EID_RESET);
		bus(0, IDX_MSEL_LOW, MSEL_RESET);
		for (int f = 0; f < 16; f++) begin
			ereg[f] = 16'($urandom);
			bus(1, IDX_EID_BASE + 8'(f), ereg[f]);
			bus(0, IDX_EID_BASE + 8'(f), ereg[f]);
		end
		for (int r = 0; r < 12; r++) begin
			msel = r < 4 ? {16{2'(r)}} : $urandom;
			bus(1, IDX_MSEL_LOW, msel[15:0]);
			bus(1, IDX_MSEL_HIGH, msel[31:16]);
			bus(0, IDX_MSEL_HIGH, msel[31:16]);
			send(11'($urandom % 2), 18'($urandom), 1'b0);
			send(0, {2'h0, ereg[r]}, 1'b0);
		end
		bus(1, IDX_SID_BASE, 16'h0008);
		xt[0] = 1'b1;
		bus(0, IDX_SID_BASE, 16'h0008);
		bus(1, IDX_CTRL, 16'h0001);
		chk = 1'b1;
		send(0, {2'h0, ereg[0]}, 1'b1);
		send(0, {2'h0, ereg[0]}, 1'b0);
		send(0, {2'h0, ereg[1]}, 1'b1);
		bus(0, 8'h24, 16'h0);
		conclude;
	end
endmodule // cfm_filter_tb_top
